// *** logic/pdt_consts.svh ***
// constants of the presettable down timer channel
`ifndef PDT_CONSTS_SVH
`define PDT_CONSTS_SVH

// counter and reload
`define PDT_CNT_W          16
`define PDT_CNT_RESET      16'hFFFF
`define PDT_CNT_ZERO       16'h0000
`define PDT_CNT_ONE        16'h0001

// clock source select codes
`define PDT_SRC_W          2
`define PDT_SRC_EXT        2'h3

// divider select and prescaler
`define PDT_DIV_W          4
`define PDT_PRESC_W        15
`define PDT_PRESC_ZERO     15'h0000
`define PDT_PRESC_ONE      15'h0001

// source pin indexes in the synchroniser bank
`define PDT_NSRC           5
`define PDT_PIN_IOSC       0
`define PDT_PIN_OSC1       1
`define PDT_PIN_OSC3       2
`define PDT_PIN_EXTERNAL_OSC_CLOCK      3
`define PDT_PIN_EVENT      4

// peripheral routing channel numbers
`define PDT_CH_SERIAL0     1
`define PDT_CH_SERIAL1     2
`define PDT_CH_CONVERTER   3

`endif

// *** logic/pdt_pkg.sv ***
// types of the presettable down timer channel
package pdt_pkg;

    typedef enum logic [1:0]
    {
        PDT_SRC_IOSC,
        PDT_SRC_OSC1,
        PDT_SRC_OSC3,
        PDT_SRC_EXTERNAL
    } pdt_src_type;

    typedef enum logic
    {
        PDT_IDLE,
        PDT_RUNNING
    } pdt_run_type;

endpackage

// *** logic/pdt_timer.sv ***
// one channel of the presettable 16-bit down timer
//
// What this block does
// RULE1 - 16-bit down counter, loaded from reload value, one step per count tick.
// RULE2 - source code 3 on event channel counts rising edges of event input.
// RULE3 - source code 3 on other channels counts the external oscillator clock.
// RULE4 - sleep with sleep stop set freezes counting, state held, resumes on wake.
// RULE5 - debug with debug run 0 freezes counting, state kept, resumes after debug.
// RULE6 - debug with debug run 1 keeps counting normally.
// RULE7 - underflow pulse sets flag and feeds peripheral clock, valid in repeat mode.
// RULE8 - underflow period is reload value plus one count ticks.
// RULE9 - repeat mode runs until run cleared, reloading on each underflow.
// RULE10 - one-shot reloads at first underflow, stops, run bit clears same cycle.
// RULE11 - software reads count twice until equal, or stops timer first.
// RULE12 - underflow sets flag, only a written 1 clears it.
// RULE13 - interrupt request only while flag set and enable is 1.
// RULE14 - software: clock, enable, mode, reload, flag and enable, preset, then run.
// RULE15 - channels 1 and 2 clock the serial masters, channel 3 triggers converter.
// RULE16 - preset command copies reload into counter, reads busy until done.
// RULE17 - software keeps reload steady while running, at least 1 in one-shot.
// RULE18 - software writes run or preset only with module enable set.
// RULE19 - foreign inputs synchronised before use, status returned as registered bits.
`timescale 1ns/1ns
`include "pdt_consts.svh"

module pdt_timer
#(
    parameter bit          HAS_EVENT  = 1'b1,
    parameter logic [1:0]  CHANNEL_ID = 2'h1
)
(
    // clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_b,
    // configuration
    input  wire logic                     i_module_enable,
    input  wire logic                     i_oneshot_select,
    input  wire logic [`PDT_SRC_W-1:0]    i_clock_source_select,
    input  wire logic [`PDT_DIV_W-1:0]    i_clock_divider_select,
    input  wire logic                     i_debug_run,
    input  wire logic                     i_sleep_clock_stop,
    input  wire logic [`PDT_CNT_W-1:0]    i_reload_value,
    input  wire logic                     i_underflow_irq_enable,
    // commands, one-cycle strobes
    input  wire logic                     i_run_write,
    input  wire logic                     i_run_wdata,
    input  wire logic                     i_preset_write,
    input  wire logic                     i_flag_clear,
    // system state
    input  wire logic                     i_sleep_mode,
    input  wire logic                     i_debug_mode,
    // clock source pins
    input  wire logic                     i_iosc_clock,
    input  wire logic                     i_osc1_clock,
    input  wire logic                     i_osc3_clock,
    input  wire logic                     i_external_osc_clock,
    input  wire logic                     i_external_event_input,
    // status
    output logic [`PDT_CNT_W-1:0]         o_count_value,
    output logic                          o_run_control,
    output logic                          o_preset_busy,
    output logic                          o_underflow_flag,
    output logic                          o_irq,
    // peripheral outputs
    output logic                          o_underflow_pulse,
    output logic                          o_serial_master_clock,
    output logic                          o_converter_trigger
);

    ////////////////////////////////////////////////////////////////////////////
    // source pin synchronisers and edge detect
    logic [`PDT_NSRC-1:0]    sync1_q;
    logic [`PDT_NSRC-1:0]    sync2_q;
    logic [`PDT_NSRC-1:0]    prev_q;
    logic [`PDT_NSRC-1:0]    pins;
    logic [`PDT_NSRC-1:0]    rise;

    assign pins[`PDT_PIN_IOSC]  = i_iosc_clock;
    assign pins[`PDT_PIN_OSC1]  = i_osc1_clock;
    assign pins[`PDT_PIN_OSC3]  = i_osc3_clock;
    assign pins[`PDT_PIN_EXTERNAL_OSC_CLOCK] = i_external_osc_clock;
    assign pins[`PDT_PIN_EVENT] = i_external_event_input;

    genvar g;
    generate
        for (g = 0; g < `PDT_NSRC; g = g + 1)
        begin : gen_sync
            always_ff @(posedge i_sys_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    prev_q[g]  <= 1'b0;
                end
                else
                begin
                    sync1_q[g] <= pins[g];     // see RULE19
                    sync2_q[g] <= sync1_q[g];
                    prev_q[g]  <= sync2_q[g];
                end
            end
            assign rise[g] = sync2_q[g] & ~prev_q[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // source selection, gating and prescaler
    function automatic logic [`PDT_PRESC_W-1:0] div_mask(input logic [`PDT_DIV_W-1:0] sel);
        div_mask = ~(`PDT_PRESC_W'(16'hFFFF) << sel);
    endfunction
    pdt_pkg::pdt_src_type      src_sel;
    logic                      src_edge;
    logic                      event_mode;
    logic                      kernel_on;
    logic [`PDT_PRESC_W-1:0]   mask;
    logic [`PDT_PRESC_W-1:0]   presc_q;
    logic                      tick;

    assign src_sel    = pdt_pkg::pdt_src_type'(i_clock_source_select);
    assign event_mode = HAS_EVENT && (i_clock_source_select == `PDT_SRC_EXT);   // see RULE2

    always_comb
    begin
        case (src_sel)
            pdt_pkg::PDT_SRC_IOSC:     src_edge = rise[`PDT_PIN_IOSC];
            pdt_pkg::PDT_SRC_OSC1:     src_edge = rise[`PDT_PIN_OSC1];
            pdt_pkg::PDT_SRC_OSC3:     src_edge = rise[`PDT_PIN_OSC3];
            default:                   src_edge = HAS_EVENT ? rise[`PDT_PIN_EVENT]   // see RULE2
                                                            : rise[`PDT_PIN_EXTERNAL_OSC_CLOCK];  // see RULE3
        endcase
    end

    // kernel clock delivery gate
    assign kernel_on = i_module_enable
                     && !(i_sleep_mode && i_sleep_clock_stop)   // see RULE4
                     && !(i_debug_mode && !i_debug_run);        // see RULE5 see RULE6

    // event counting uses each edge
    assign mask = event_mode ? `PDT_PRESC_ZERO : div_mask(i_clock_divider_select);
    assign tick = kernel_on && src_edge && ((presc_q & mask) == mask);

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            presc_q <= `PDT_PRESC_ZERO;
        end
        else if (!i_module_enable)
        begin
            presc_q <= `PDT_PRESC_ZERO;
        end
        else if (kernel_on && src_edge)
        begin
            presc_q <= ((presc_q & mask) == mask) ? `PDT_PRESC_ZERO : presc_q + `PDT_PRESC_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run control
    pdt_pkg::pdt_run_type    run_q;
    logic                    underflow;
    logic [`PDT_CNT_W-1:0]   count_q;

    assign underflow = (run_q == pdt_pkg::PDT_RUNNING) && tick && (count_q == `PDT_CNT_ZERO);

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            run_q <= pdt_pkg::PDT_IDLE;
        end
        else
        begin
            case (run_q)
                pdt_pkg::PDT_IDLE:
                begin
                    if (i_run_write && i_run_wdata && i_module_enable)
                    begin
                        run_q <= pdt_pkg::PDT_RUNNING;
                    end
                end
                default:
                begin
                    if (i_run_write && !i_run_wdata)
                    begin
                        run_q <= pdt_pkg::PDT_IDLE;      // see RULE9
                    end
                    else if (underflow && i_oneshot_select)
                    begin
                        run_q <= pdt_pkg::PDT_IDLE;      // see RULE10
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // preset command
    logic    preset_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            preset_q <= 1'b0;
        end
        else if (preset_q)
        begin
            preset_q <= 1'b0;                            // see RULE16
        end
        else if (i_preset_write && i_module_enable)
        begin
            preset_q <= 1'b1;                            // see RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // down counter
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            count_q <= `PDT_CNT_RESET;
        end
        else if (preset_q)
        begin
            count_q <= i_reload_value;                   // see RULE16
        end
        else if (underflow)
        begin
            count_q <= i_reload_value;                   // see RULE8 see RULE9 see RULE10
        end
        else if ((run_q == pdt_pkg::PDT_RUNNING) && tick)
        begin
            count_q <= count_q - `PDT_CNT_ONE;           // see RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag, request and peripheral outputs
    logic    flag_q;
    logic    flag_d;
    logic    irq_q;
    logic    pulse_q;
    logic    pclk_q;
    logic    trig_q;
    // a new underflow beats a clear in the same cycle
    assign flag_d = underflow ? 1'b1 : (i_flag_clear ? 1'b0 : flag_q);   // see RULE12

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            irq_q  <= flag_d && i_underflow_irq_enable;  // see RULE13
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pulse_q <= 1'b0;
            pclk_q  <= 1'b0;
            trig_q  <= 1'b0;
        end
        else
        begin
            pulse_q <= underflow;                        // see RULE7
            if ((CHANNEL_ID == `PDT_CH_SERIAL0 || CHANNEL_ID == `PDT_CH_SERIAL1)
                && underflow && !i_oneshot_select)
            begin
                pclk_q <= ~pclk_q;                       // see RULE7 see RULE15
            end
            trig_q <= (CHANNEL_ID == `PDT_CH_CONVERTER) && underflow;   // see RULE15
        end
    end

    assign o_count_value         = count_q;
    assign o_run_control         = (run_q == pdt_pkg::PDT_RUNNING);
    assign o_preset_busy         = preset_q;
    assign o_underflow_flag      = flag_q;
    assign o_irq                 = irq_q;
    assign o_underflow_pulse     = pulse_q;
    assign o_serial_master_clock = pclk_q;
    assign o_converter_trigger   = trig_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_under;
        underflow;
    endsequence
    sequence s_reloaded;
        ##1 (count_q == $past(i_reload_value));
    endsequence
    chk_counter_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE1
        (run_q == pdt_pkg::PDT_RUNNING && tick && count_q != `PDT_CNT_ZERO && !preset_q)
        |=> (count_q == $past(count_q) - `PDT_CNT_ONE))
        else $error("counter did not step down by one");
    chk_underflow_reload: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE8
        (s_under and !preset_q) |-> s_reloaded)
        else $error("underflow did not reload counter");
    chk_gate_sleep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE4
        (i_sleep_mode && i_sleep_clock_stop && !preset_q) |=> $stable(count_q))
        else $error("counter moved while sleep stopped its clock");
    chk_gate_debug: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE5
        (i_debug_mode && !i_debug_run && !preset_q) |=> $stable(count_q))
        else $error("counter moved in debug without debug run");
    chk_oneshot_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE10
        (s_under and i_oneshot_select) |=> !o_run_control)
        else $error("one-shot run bit not cleared at underflow");
    chk_repeat_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE9
        (s_under and !i_oneshot_select and !i_run_write) |=> o_run_control)
        else $error("repeat mode stopped at underflow");
    chk_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE12
        s_under |=> o_underflow_flag ##0 o_underflow_pulse)
        else $error("underflow did not raise flag and pulse");
    chk_flag_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE12
        (o_underflow_flag && !i_flag_clear) |=> o_underflow_flag)
        else $error("flag dropped without a clear");
    chk_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE13
        ##1 (o_irq == (o_underflow_flag && $past(i_underflow_irq_enable))))
        else $error("interrupt request does not follow flag and enable");
    chk_preset_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE16
        (i_preset_write && i_module_enable && !preset_q)
        |=> preset_q ##1 (!preset_q && count_q == $past(i_reload_value)))
        else $error("preset did not complete in one cycle");
    chk_converter_route: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see RULE15
        o_converter_trigger |-> (CHANNEL_ID == `PDT_CH_CONVERTER) && o_underflow_pulse)
        else $error("converter trigger on wrong channel or without underflow");
endmodule

// *** testbench/tb_pdt_timer.sv ***
// self-checking testbench of the presettable down timer channel
`timescale 1ns/1ns
`include "pdt_consts.svh"

module tb_pdt_timer;
    logic                  i_sys_clk = 1'b0;
    logic                  i_rst_b = 1'b0;
    logic                  men = 1'b0, osel = 1'b0, drun = 1'b0, sstop = 1'b0, irqen = 1'b0;
    logic [1:0]            src = 2'h0;
    logic [3:0]            div = 4'h0;
    logic [15:0]           rld = 16'h0000;
    logic                  runw = 1'b0, rund = 1'b0, prew = 1'b0, clr = 1'b0, slp = 1'b0, dbg = 1'b0;
    logic [7:0]            ph = 8'h00;
    logic [15:0]           cnt;
    logic                  run, busy, flag, irq, pulse, smclk, ctrig, smprev;
    logic [31:0]           seed = 32'h9f4ff4c4;
    int                    mismatches = 0;
    int                    n_compared = 0;
    int                    n;

    pdt_timer pdt_timer_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_module_enable(men),
        .i_oneshot_select(osel), .i_clock_source_select(src), .i_clock_divider_select(div),
        .i_debug_run(drun), .i_sleep_clock_stop(sstop), .i_reload_value(rld),
        .i_underflow_irq_enable(irqen), .i_run_write(runw), .i_run_wdata(rund),
        .i_preset_write(prew), .i_flag_clear(clr), .i_sleep_mode(slp), .i_debug_mode(dbg),
        .i_iosc_clock(ph[2]), .i_osc1_clock(ph[2]), .i_osc3_clock(ph[2]),
        .i_external_osc_clock(ph[2]), .i_external_event_input(ph[3]), .o_count_value(cnt),
        .o_run_control(run), .o_preset_busy(busy), .o_underflow_flag(flag), .o_irq(irq),
        .o_underflow_pulse(pulse), .o_serial_master_clock(smclk), .o_converter_trigger(ctrig));

    always #50 i_sys_clk = ~i_sys_clk;

    // clock pins: period 8 cycles; event pin: period 16 cycles
    always @(negedge i_sys_clk) ph <= ph + 8'h01;

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // expected underflow period in system cycles
    function automatic int exp_period(input logic [1:0] s, input logic [3:0] d, input logic [15:0] r);
        if (s == `PDT_SRC_EXT)
            return (int'(r) + 1) * 16;
        return ((int'(r) + 1) * 8) << d;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one-cycle strobe: 0 run write, 1 preset, 2 flag clear
    task automatic cmd(input int k, input logic d);
        @(negedge i_sys_clk);
        runw = (k == 0);
        rund = d;
        prew = (k == 1);
        clr = (k == 2);
        @(negedge i_sys_clk);
        runw = 1'b0;
        prew = 1'b0;
        clr = 1'b0;
    endtask

    task automatic wait_pulse(output int cyc);
        cyc = 0;
        do
        begin
            @(negedge i_sys_clk);
            cyc++;
        end while (pulse !== 1'b1 && cyc < 5000);
        if (cyc >= 5000)
            chk(16'h0000, 16'h0001, "no underflow pulse");
    endtask

    task automatic preset_chk();
        cmd(1, 1'b0);
        chk(busy, 1'b1, "preset busy");
        @(negedge i_sys_clk);
        chk(busy, 1'b0, "preset busy end");
        chk(cnt, rld, "preset count");
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #(40000 * 100);
        mismatches++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        chk(cnt, 16'hFFFF, "reset count");
        chk({run, busy, flag, irq, pulse}, 16'h0000, "reset status");
        // refused preset while disabled
        rld = 16'h0005;
        cmd(1, 1'b0);
        chk(busy, 1'b0, "preset refused");
        men = 1'b1;
        // repeat mode across all sources and small dividers
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            rld = 16'h0001 + 16'(seed % 6);
            div = 4'(seed[8]);
            src = k[1:0];
            irqen = seed[9];
            preset_chk();
            cmd(0, 1'b1);
            chk(run, 1'b1, "run set");
            wait_pulse(n);
            chk(cnt, rld, "reload at underflow");
            smprev = smclk;
            cmd(2, 1'b1);
            chk(flag, 1'b0, "flag cleared");
            wait_pulse(n);
            chk(16'(n + 2), 16'(exp_period(src, div, rld)), "underflow period");
            chk(flag, 1'b1, "flag set");
            chk(irq, irqen, "irq follows enable");
            chk(smclk, !smprev, "serial clock toggle");
            chk(ctrig, 1'b0, "no converter trigger");
            chk(run, 1'b1, "still running");
            cmd(0, 1'b0);
            chk(run, 1'b0, "run stopped");
            cmd(2, 1'b1);
            chk(irq, 1'b0, "irq drops with flag");
        end
        // one-shot
        osel = 1'b1;
        src = `PDT_SRC_EXT;
        rld = 16'h0002;
        preset_chk();
        cmd(0, 1'b1);
        smprev = smclk;
        wait_pulse(n);
        chk(run, 1'b0, "oneshot stops");
        chk(cnt, rld, "oneshot reload");
        chk(smclk, smprev, "no serial clock in oneshot");
        repeat (100) @(negedge i_sys_clk);
        chk(cnt, rld, "oneshot stays stopped");
        // freeze table: sleep+stop, debug without run, debug with run, sleep without stop
        osel = 1'b0;
        src = 2'h0;
        div = 4'h0;
        rld = 16'h00C8;
        preset_chk();
        cmd(0, 1'b1);
        for (int m = 0; m < 4; m++)
        begin
            slp = (m == 0 || m == 3);
            sstop = (m == 0);
            dbg = (m == 1 || m == 2);
            drun = (m == 2);
            @(negedge i_sys_clk);
            @(negedge i_sys_clk);
            @(negedge i_sys_clk);
            n = int'(cnt);
            repeat (64) @(negedge i_sys_clk);
            if (m < 2)
                chk(cnt, 16'(n), "count frozen");
            else
                chk(16'(n - int'(cnt)), 16'h0008, "count runs");
            slp = 1'b0;
            dbg = 1'b0;
            n = int'(cnt);
            repeat (64) @(negedge i_sys_clk);
            chk(16'(n - int'(cnt)), 16'h0008, "count resumes");
        end
        end_of_test();
    end
endmodule
